// [verilog/wit_top.v]
// Functional notes
// RULE1: reset control loads 1F on pin reset, standby
// RULE2: watchdog flag set on FF to 00 wrap
// RULE3: watchdog flag cleared by read-one then write-zero
// RULE4: reset enable gates internal reset on overflow
// RULE5: internal reset reinitialises count and control only
// RULE6: reset control bit5 reads 0, bits4-0 read 1
// RULE7: count and control accept word writes only
// RULE8: shared write address, 5A count, A5 control
// RULE9: reset control needs word write at own address
// RULE10: A5 with 00 clears flag, keeps enable
// RULE11: 5A copies bit6 into enable, keeps flag
// RULE12: byte reads at base, base+1, base+3
// RULE13: watchdog mode drives overflow pin low
// RULE14: overflow pin low for 128 watchdog clocks
// RULE15: internal reset starts together, lasts 512 clocks
// RULE16: pin reset beats overflow, flag ends cleared
// RULE17: internal reset never reaches port registers
// RULE18: interval mode raises interrupt every overflow
// RULE19: standby entry refused while timer runs
// RULE20: after wake, wrap signals stable clock, ends standby
// RULE21: software rewrites count before overflow
// RULE22: software picks divider longer than settling time
// RULE23: count clears at reset or stop, holds in standby
// RULE24: three-bit select picks one of eight dividers
// RULE25: interval flag set only in interval mode
// RULE26: unkeyed word writes change nothing
`timescale 1ns/1ps
`include "wit_defs.vh"

module wit_top (
    core_clk,
    reset_n,
    external_reset_n,
    module_clk_en,
    bus_addr,
    bus_wr,
    bus_rd,
    bus_word,
    bus_wdata,
    bus_rdata,
    standby_active,
    nmi_wake,
    standby_entry_allowed,
    standby_release,
    overflow_out_n,
    internal_reset,
    interval_interrupt
);
    input  wire        core_clk;
    input  wire        reset_n;
    input  wire        external_reset_n;
    input  wire        module_clk_en;
    input  wire [31:0] bus_addr;
    input  wire        bus_wr;
    input  wire        bus_rd;
    input  wire        bus_word;
    input  wire [15:0] bus_wdata;
    output reg  [7:0]  bus_rdata;
    input  wire        standby_active;
    input  wire        nmi_wake;
    output reg         standby_entry_allowed;
    output reg         standby_release;
    output wire        overflow_out_n;
    output wire        internal_reset;
    output reg         interval_interrupt;

    // pin reset synchroniser and filter
    reg        pin_s1;
    reg        pin_s2;
    reg        pin_s3;
    reg        pin_level;

    // timer control fields
    reg [7:0]  watchdog_count;
    reg        interval_overflow_flag;
    reg        mode_select;
    reg        timer_run;
    reg [2:0]  clock_divider_select;
    reg        ovf_armed;

    // reset control fields
    reg        watchdog_overflow_flag;
    reg        internal_reset_enable;
    reg        watchdog_overflow_flag_armed;

    reg        waking;
    reg [7:0]  next_rdata;

    wire       pin_reset;
    wire       wdt_reset;
    wire       tick;
    wire       counting;
    wire       wrap;
    wire       wd_overflow;
    wire       it_overflow;
    wire       wake_overflow;
    wire       prescale_clear;
    wire [7:0] key;
    wire [7:0] wr_data;
    wire       wr_timer;
    wire       wr_reset;
    wire       wr_count;
    wire       wr_control;
    wire       wr_flag_clear;
    wire       wr_enable;
    wire       rd_byte;
    wire       key_is_count;
    wire       key_is_ctrl;
    wire       rd_ctrl_hit;
    wire       rd_rst_hit;
    wire [7:0] control_view;
    wire [7:0] reset_view;

    function wit_hit;
        input [31:0] addr;
        input [31:0] target;
        begin
            wit_hit = (addr == target);
        end
    endfunction

    // filter starts low, so the block waits in pin reset until the pin is seen high
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1    <= 1'b0;
            pin_s2    <= 1'b0;
            pin_s3    <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            pin_s1 <= external_reset_n;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3) begin
                pin_level <= pin_s3;
            end
        end
    end

    assign pin_reset = ~pin_level;

    // bus decode
    assign key           = bus_wdata[15:8];
    assign wr_data       = bus_wdata[7:0];
    assign wr_timer      = bus_wr & bus_word & wit_hit(bus_addr, `WIT_ADDR_WR_TIMER); // RULE7
    assign wr_reset      = bus_wr & bus_word & wit_hit(bus_addr, `WIT_ADDR_WR_RESET); // RULE9
    assign key_is_count  = (key == `WIT_KEY_COUNT);
    assign key_is_ctrl   = (key == `WIT_KEY_CONTROL);
    assign wr_count      = wr_timer & key_is_count; // RULE8 RULE26
    assign wr_control    = wr_timer & key_is_ctrl; // RULE8 RULE26
    assign wr_flag_clear = wr_reset & key_is_ctrl & (wr_data == `WIT_FLAG_CLEAR_DATA); // RULE10
    assign wr_enable     = wr_reset & key_is_count; // RULE11 RULE26
    assign rd_byte       = bus_rd & ~bus_word;
    assign rd_ctrl_hit   = rd_byte & wit_hit(bus_addr, `WIT_ADDR_RD_CONTROL);
    assign rd_rst_hit    = rd_byte & wit_hit(bus_addr, `WIT_ADDR_RD_RESET);

    assign control_view = {interval_overflow_flag, mode_select, timer_run, `WIT_RSV_CONTROL, clock_divider_select};
    assign reset_view   = {watchdog_overflow_flag, internal_reset_enable,
                           `WIT_RSV_RESET_HI, `WIT_RSV_RESET_LO}; // RULE6

    // counting and overflow
    assign counting       = timer_run | waking;
    assign prescale_clear = pin_reset | wdt_reset | ~counting;
    assign wrap           = tick & counting & (watchdog_count == `WIT_COUNT_MAX);
    assign wd_overflow    = wrap & timer_run & mode_select; // RULE13
    assign it_overflow    = wrap & timer_run & ~mode_select; // RULE18
    assign wake_overflow  = wrap & waking; // RULE20

    wit_prescaler u_prescaler (
        .core_clk             (core_clk),
        .reset_n              (reset_n),
        .module_clk_en        (module_clk_en),
        .clear                (prescale_clear),
        .clock_divider_select (clock_divider_select),
        .tick                 (tick)
    );

    wit_pulse_timer u_overflow_pulse (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clear    (pin_reset),
        .start    (wd_overflow), // RULE13
        .tick     (module_clk_en),
        .length   (`WIT_OVO_CYCLES), // RULE14
        .active   (),
        .active_n (overflow_out_n)
    );

    // internal reset output feeds only the cpu side, never port or pin function registers
    wit_pulse_timer u_internal_reset (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clear    (pin_reset), // RULE17
        .start    (wd_overflow & internal_reset_enable), // RULE4 RULE15
        .tick     (module_clk_en),
        .length   (`WIT_IRST_CYCLES), // RULE15
        .active   (internal_reset),
        .active_n ()
    );

    // count and control stay cleared for the whole internal reset span
    assign wdt_reset = internal_reset; // RULE5

    // counter
    // frozen in standby so the wake count starts from the held value
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_count <= `WIT_COUNT_RESET;
        end else if (pin_reset || wdt_reset) begin
            watchdog_count <= `WIT_COUNT_RESET; // RULE5 RULE23
        end else if (standby_active && !waking) begin
            watchdog_count <= watchdog_count; // RULE23
        end else if (wr_count) begin
            watchdog_count <= wr_data; // RULE8
        end else if (!counting) begin
            watchdog_count <= `WIT_COUNT_RESET; // RULE23
        end else if (tick) begin
            watchdog_count <= watchdog_count + 8'h01;
        end
    end

    // timer control
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            interval_overflow_flag <= 1'b0;
            mode_select            <= 1'b0;
            timer_run              <= 1'b0;
            clock_divider_select   <= 3'h0;
        end else if (pin_reset || wdt_reset) begin
            interval_overflow_flag <= 1'b0; // RULE5
            mode_select            <= 1'b0;
            timer_run              <= 1'b0;
            clock_divider_select   <= 3'h0;
        end else if (standby_active) begin
            interval_overflow_flag <= 1'b0;
            mode_select            <= 1'b0;
            timer_run              <= 1'b0;
        end else begin
            if (it_overflow) begin
                interval_overflow_flag <= 1'b1; // RULE25
            end else if (wr_control && !wr_data[`WIT_BIT_OVF] && ovf_armed) begin
                interval_overflow_flag <= 1'b0;
            end
            if (wr_control) begin
                mode_select          <= wr_data[`WIT_BIT_MODE];
                timer_run            <= wr_data[`WIT_BIT_RUN];
                clock_divider_select <= wr_data[2:0];
            end
        end
    end

    // arming needs a read that saw the flag set, so a blind write cannot clear it
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ovf_armed <= 1'b0;
        end else if (pin_reset || wdt_reset || standby_active) begin
            ovf_armed <= 1'b0;
        end else if (rd_ctrl_hit && interval_overflow_flag) begin
            ovf_armed <= 1'b1;
        end else if (wr_control) begin
            ovf_armed <= 1'b0;
        end
    end

    // reset control, kept through the internal reset
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_overflow_flag <= 1'b0;
            internal_reset_enable  <= 1'b0;
        end else if (pin_reset || standby_active) begin
            watchdog_overflow_flag <= 1'b0; // RULE1 RULE16
            internal_reset_enable  <= 1'b0; // RULE1
        end else begin
            // a set in the same cycle as a clear wins
            if (wd_overflow) begin
                watchdog_overflow_flag <= 1'b1; // RULE2
            end else if (wr_flag_clear && watchdog_overflow_flag_armed) begin
                watchdog_overflow_flag <= 1'b0; // RULE3 RULE10
            end
            if (wr_enable) begin
                internal_reset_enable <= wr_data[`WIT_BIT_INTERNAL_RESET_ENABLE]; // RULE11
            end
        end
    end

    // same arming scheme for the watchdog flag, kept through the internal reset
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_overflow_flag_armed <= 1'b0;
        end else if (pin_reset || standby_active) begin
            watchdog_overflow_flag_armed <= 1'b0;
        end else if (rd_rst_hit && watchdog_overflow_flag) begin
            watchdog_overflow_flag_armed <= 1'b1; // RULE3
        end else if (wr_flag_clear) begin
            watchdog_overflow_flag_armed <= 1'b0;
        end
    end

    // standby wake timing
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            waking          <= 1'b0;
            standby_release <= 1'b0;
        end else if (pin_reset) begin
            waking          <= 1'b0;
            standby_release <= 1'b0;
        end else begin
            standby_release <= wake_overflow; // RULE20
            if (wake_overflow || !standby_active) begin
                waking <= 1'b0;
            end else if (nmi_wake) begin
                waking <= 1'b1; // RULE20
            end
        end
    end

    // read path, word reads return zero
    always @* begin
        next_rdata = 8'h00;
        if (rd_byte) begin
            if (wit_hit(bus_addr, `WIT_ADDR_RD_CONTROL)) begin
                next_rdata = control_view; // RULE12
            end else if (wit_hit(bus_addr, `WIT_ADDR_RD_COUNT)) begin
                next_rdata = watchdog_count; // RULE12
            end else if (wit_hit(bus_addr, `WIT_ADDR_RD_RESET)) begin
                next_rdata = reset_view; // RULE12
            end
        end
    end

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_rdata             <= 8'h00;
            interval_interrupt    <= 1'b0;
            standby_entry_allowed <= 1'b0;
        end else begin
            bus_rdata             <= next_rdata;
            interval_interrupt    <= it_overflow; // RULE18
            standby_entry_allowed <= ~timer_run; // RULE19
        end
    end

endmodule

// [pkg/wit_defs.vh]
`ifndef WIT_DEFS_VH
`define WIT_DEFS_VH

// cpu addresses
`define WIT_ADDR_WR_TIMER   32'hFFFF1000
`define WIT_ADDR_WR_RESET   32'hFFFF1002
`define WIT_ADDR_RD_CONTROL 32'hFFFF1000
`define WIT_ADDR_RD_COUNT   32'hFFFF1001
`define WIT_ADDR_RD_RESET   32'hFFFF1003

// write keys in the upper byte
`define WIT_KEY_COUNT       8'h5A
`define WIT_KEY_CONTROL     8'hA5
`define WIT_FLAG_CLEAR_DATA 8'h00

// reset values
`define WIT_COUNT_RESET     8'h00
`define WIT_RESET_CTL_INIT  8'h1F
`define WIT_COUNT_MAX       8'hFF

// field positions
`define WIT_BIT_OVF         7
`define WIT_BIT_MODE        6
`define WIT_BIT_RUN         5
`define WIT_BIT_WATCHDOG_OVERFLOW_FLAG        7
`define WIT_BIT_INTERNAL_RESET_ENABLE        6
`define WIT_RSV_CONTROL     2'h3
`define WIT_RSV_RESET_HI    1'h0
`define WIT_RSV_RESET_LO    5'h1F

// divider masks, tick when masked bits are all ones
`define WIT_DIV_2           12'h001
`define WIT_DIV_4           12'h003
`define WIT_DIV_8           12'h007
`define WIT_DIV_32          12'h01F
`define WIT_DIV_256         12'h0FF
`define WIT_DIV_1024        12'h3FF
`define WIT_DIV_2048        12'h7FF
`define WIT_DIV_4096        12'hFFF

// pulse lengths in watchdog clock cycles
`define WIT_OVO_CYCLES      10'h080
`define WIT_IRST_CYCLES     10'h200

`endif

// [verilog/wit_prescaler.v]
`timescale 1ns/1ps
`include "wit_defs.vh"

module wit_prescaler (
    core_clk,
    reset_n,
    module_clk_en,
    clear,
    clock_divider_select,
    tick
);
    input  wire        core_clk;
    input  wire        reset_n;
    input  wire        module_clk_en;
    input  wire        clear;
    input  wire [2:0]  clock_divider_select;
    output wire        tick;

    reg  [11:0] div_cnt;
    wire [11:0] mask;

    function [11:0] wit_div_mask;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    wit_div_mask = `WIT_DIV_2;
                3'h1:    wit_div_mask = `WIT_DIV_4;
                3'h2:    wit_div_mask = `WIT_DIV_8;
                3'h3:    wit_div_mask = `WIT_DIV_32;
                3'h4:    wit_div_mask = `WIT_DIV_256;
                3'h5:    wit_div_mask = `WIT_DIV_1024;
                3'h6:    wit_div_mask = `WIT_DIV_2048;
                default: wit_div_mask = `WIT_DIV_4096;
            endcase
        end
    endfunction

    assign mask = wit_div_mask(clock_divider_select);
    assign tick = module_clk_en & ~clear & ((div_cnt & mask) == mask); // RULE24

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= 12'h000;
        end else if (clear) begin
            div_cnt <= 12'h000;
        end else if (module_clk_en) begin
            div_cnt <= div_cnt + 12'h001;
        end
    end

endmodule

// [verilog/wit_pulse_timer.v]
`timescale 1ns/1ps
`include "wit_defs.vh"

module wit_pulse_timer (
    core_clk,
    reset_n,
    clear,
    start,
    tick,
    length,
    active,
    active_n
);
    input  wire        core_clk;
    input  wire        reset_n;
    input  wire        clear;
    input  wire        start;
    input  wire        tick;
    input  wire [9:0]  length;
    output reg         active;
    output reg         active_n;

    reg [9:0] remain;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            remain   <= 10'h000;
            active   <= 1'b0;
            active_n <= 1'b1;
        end else if (clear) begin
            remain   <= 10'h000;
            active   <= 1'b0;
            active_n <= 1'b1;
        end else if (start) begin
            remain   <= length;
            active   <= 1'b1;
            active_n <= 1'b0;
        end else if (active && tick) begin
            remain <= remain - 10'h001;
            if (remain == 10'h001) begin
                active   <= 1'b0;
                active_n <= 1'b1;
            end
        end
    end

endmodule

// [dv/wit_chk.sv]
`timescale 1ns/1ps
`include "wit_defs.vh"

module wit_chk (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        external_reset_n,
    input wire logic        module_clk_en,
    input wire logic [31:0] bus_addr,
    input wire logic        bus_rd,
    input wire logic        bus_word,
    input wire logic [7:0]  bus_rdata,
    input wire logic        standby_active,
    input wire logic        standby_release,
    input wire logic        overflow_out_n,
    input wire logic        internal_reset,
    input wire logic        interval_interrupt
);
    logic [9:0] ovo_cnt;
    logic [9:0] irst_cnt;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // enables seen while each pulse is active
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ovo_cnt  <= 10'h000;
            irst_cnt <= 10'h000;
        end else begin
            ovo_cnt  <= overflow_out_n ? 10'h000 : ovo_cnt + {9'h000, module_clk_en};
            irst_cnt <= !internal_reset ? 10'h000 : irst_cnt + {9'h000, module_clk_en};
        end
    end

    a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_word_read_zero: assert property ($past(bus_rd && bus_word) |-> bus_rdata == 8'h00)
        else $error("word read returned data");
    a_rst_reserved: assert property ($past(bus_rd && !bus_word && bus_addr == `WIT_ADDR_RD_RESET)
        |-> bus_rdata[5:0] == 6'h1F)
        else $error("reset control reserved bits wrong");
    a_ctl_reserved: assert property ($past(bus_rd && !bus_word && bus_addr == `WIT_ADDR_RD_CONTROL)
        |-> bus_rdata[4:3] == 2'h3)
        else $error("control reserved bits wrong");
    a_ovo_length: assert property (!overflow_out_n |-> ovo_cnt <= 10'h080)
        else $error("overflow pin held too long");
    a_irst_length: assert property (internal_reset |-> irst_cnt <= 10'h200)
        else $error("internal reset held too long");
    a_irst_start: assert property ($rose(internal_reset) |-> $fell(overflow_out_n))
        else $error("internal reset not aligned with overflow pin");
    a_irq_single: assert property (interval_interrupt |=> !interval_interrupt)
        else $error("interval interrupt longer than one cycle");
    a_irq_mode_excl: assert property ($fell(overflow_out_n) |-> !interval_interrupt)
        else $error("interrupt and overflow pin together");
    a_release_pulse: assert property (standby_release |-> $past(standby_active) ##1 !standby_release)
        else $error("standby release outside standby or too long");
    a_pin_reset_wins: assert property (!external_reset_n [*8] |-> overflow_out_n && !internal_reset)
        else $error("pulses survive pin reset");

    c_ovo: cover property ($fell(overflow_out_n));
    c_irst: cover property ($rose(internal_reset));
    c_irq: cover property (interval_interrupt);
    c_release: cover property (standby_release);
endmodule

bind wit_top wit_chk chk_u (
    .core_clk           (core_clk),
    .reset_n            (reset_n),
    .external_reset_n   (external_reset_n),
    .module_clk_en      (module_clk_en),
    .bus_addr           (bus_addr),
    .bus_rd             (bus_rd),
    .bus_word           (bus_word),
    .bus_rdata          (bus_rdata),
    .standby_active     (standby_active),
    .standby_release    (standby_release),
    .overflow_out_n     (overflow_out_n),
    .internal_reset     (internal_reset),
    .interval_interrupt (interval_interrupt)
);

// [dv/wit_top_tb.sv]
`timescale 1ns/1ps
`include "wit_defs.vh"

module wit_top_tb;
    localparam [31:0] AT = `WIT_ADDR_WR_TIMER;
    localparam [31:0] AR = `WIT_ADDR_WR_RESET;
    localparam [31:0] RC = `WIT_ADDR_RD_CONTROL;
    localparam [31:0] RN = `WIT_ADDR_RD_COUNT;
    localparam [31:0] RR = `WIT_ADDR_RD_RESET;
    reg         core_clk, reset_n, external_reset_n, module_clk_en;
    reg         bus_wr, bus_rd, bus_word, standby_active, nmi_wake;
    reg  [31:0] bus_addr;
    reg  [15:0] bus_wdata;
    wire [7:0]  bus_rdata;
    wire        standby_entry_allowed, standby_release, overflow_out_n, internal_reset, interval_interrupt;
    integer     errors, cmp_count, n_ovo, n_irst, i;

    wit_top dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .external_reset_n(external_reset_n),
        .module_clk_en(module_clk_en), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .standby_active(standby_active), .nmi_wake(nmi_wake),
        .standby_entry_allowed(standby_entry_allowed), .standby_release(standby_release),
        .overflow_out_n(overflow_out_n), .internal_reset(internal_reset),
        .interval_interrupt(interval_interrupt)
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task end_sim;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input string name, input [31:0] exp, input [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task wr(input [31:0] a, input [15:0] d, input w);
        @(posedge core_clk);
        #1;
        bus_addr = a;
        bus_wdata = d;
        bus_word = w;
        bus_wr = 1'b1;
        @(posedge core_clk);
        #1;
        bus_wr = 1'b0;
    endtask

    task rd(input [31:0] a, input w, input [7:0] e);
        @(posedge core_clk);
        #1;
        bus_addr = a;
        bus_word = w;
        bus_rd = 1'b1;
        @(posedge core_clk);
        #1;
        bus_rd = 1'b0;
        chk($sformatf("read %h", a), {24'h0, e}, {24'h0, bus_rdata});
    endtask

    function hit(input [1:0] k);
        case (k)
            2'h0: hit = interval_interrupt === 1'b1;
            2'h1: hit = overflow_out_n === 1'b0;
            default: hit = standby_release === 1'b1;
        endcase
    endfunction

    // bounded wait for an output event
    task wt(input [1:0] k);
        for (i = 0; i < 1200 && !hit(k); i++) begin
            @(posedge core_clk);
            #1;
        end
        cmp_count++;
        if (!hit(k)) begin
            errors++;
            $display("[FAIL] event %0d expected 1 seen 0", k);
            end_sim;
        end
    endtask

    initial begin
        errors = 0; cmp_count = 0; reset_n = 0; external_reset_n = 1; module_clk_en = 1;
        bus_wr = 0; bus_rd = 0; bus_word = 0; bus_addr = 0; bus_wdata = 0; standby_active = 0; nmi_wake = 0;
        repeat (12) @(posedge core_clk);
        #1 reset_n = 1;
        repeat (6) @(posedge core_clk);
        rd(RR, 0, 8'h1F);
        rd(RC, 0, 8'h18);
        rd(RN, 0, 8'h00);
        wr(AT, 16'hA527, 1);
        wr(AT, 16'h5A37, 1);
        rd(RN, 0, 8'h37);
        rd(RC, 0, 8'h3F);
        wr(AT, 16'h5A55, 0);
        wr(AT, 16'h1255, 1);
        rd(RN, 0, 8'h37);
        wr(AR, 16'h5A40, 0);
        rd(RR, 0, 8'h1F);
        wr(AR, 16'h5A40, 1);
        rd(RR, 0, 8'h5F);
        rd(RR, 1, 8'h00);
        rd(32'hFFFF1004, 0, 8'h00);
        wr(AT, 16'hA521, 1);
        wr(AT, 16'h5AFE, 1);
        wt(2'h0);
        @(posedge core_clk);
        #1;
        wt(2'h0);
        chk("divide by 4 period", 256 * 4 - 1, i);
        rd(RC, 0, 8'hB9);
        rd(RR, 0, 8'h5F);
        chk("entry allowed", 0, standby_entry_allowed);
        wr(AT, 16'hA520, 1);
        rd(RC, 0, 8'h38);
        wr(AT, 16'hA500, 1);
        rd(RN, 0, 8'h00);
        chk("entry allowed", 1, standby_entry_allowed);
        wr(AT, 16'hA560, 1);
        wr(AT, 16'h5AFE, 1);
        wt(2'h1);
        chk("internal reset", 1, internal_reset);
        n_ovo = 1;
        n_irst = 1;
        repeat (700) begin
            @(posedge core_clk);
            #1;
            if (overflow_out_n === 1'b0) n_ovo++;
            if (internal_reset === 1'b1) n_irst++;
        end
        chk("overflow pin cycles", 128, n_ovo);
        chk("internal reset cycles", 512, n_irst);
        rd(RC, 0, 8'h18);
        rd(RN, 0, 8'h00);
        wr(AR, 16'h5AC0, 1);
        wr(AR, 16'hA500, 1);
        rd(RR, 0, 8'hDF);
        wr(AR, 16'hA500, 1);
        rd(RR, 0, 8'h5F);
        wr(AR, 16'h5A00, 1);
        wr(AT, 16'hA560, 1);
        n_ovo = 0;
        repeat (3) begin
            repeat (400) begin
                @(posedge core_clk);
                #1;
                if (overflow_out_n === 1'b0) n_ovo++;
            end
            wr(AT, 16'h5A00, 1);
        end
        chk("overflow while kicked", 0, n_ovo);
        wr(AT, 16'h5AFE, 1);
        wt(2'h1);
        chk("internal reset", 0, internal_reset);
        external_reset_n = 0;
        repeat (10) @(posedge core_clk);
        #1 external_reset_n = 1;
        repeat (8) @(posedge core_clk);
        #1;
        chk("overflow pin", 1, overflow_out_n);
        rd(RR, 0, 8'h1F);
        rd(RC, 0, 8'h18);
        wr(AT, 16'hA500, 1);
        wr(AR, 16'h5A40, 1);
        chk("entry allowed", 1, standby_entry_allowed);
        @(posedge core_clk);
        #1 standby_active = 1;
        rd(RR, 0, 8'h1F);
        @(posedge core_clk);
        #1 nmi_wake = 1;
        @(posedge core_clk);
        #1 nmi_wake = 0;
        wt(2'h2);
        @(posedge core_clk);
        #1 standby_active = 0;
        end_sim;
    end
endmodule
